// [rtl/codec_pkg.sv]
package codec_pkg;

  // ---------------------------------------------------------------
  // sizes and reset values
  // ---------------------------------------------------------------
  localparam int BYTE_W = 8; // parallel byte width
  localparam int CODE_W = 10; // transmission character width
  localparam int FIFO_W = 9; // byte plus special flag
  localparam int FIFO_DEPTH = 32; // transmit buffer depth
  localparam logic [3:0] LAST_BIT = 4'h9; // last bit slot of a character
  localparam logic RD_RESET = 1'b0; // running disparity after reset: negative
  localparam logic [7:0] IDLE_BYTE = 8'hBC; // idle character, special 28.5
  localparam logic [9:0] IDLE_CODE_NEG = 10'h0FA; // idle character, negative column
  localparam logic [9:0] IDLE_CODE_POS = 10'h305; // idle character, positive column
  localparam logic [6:0] COMMA_NEG = 7'h1F; // comma pattern abcdeif 0011111
  localparam logic [6:0] COMMA_POS = 7'h60; // comma pattern abcdeif 1100000
  localparam int SPECIAL_COUNT = 12; // number of valid special characters

  // ---------------------------------------------------------------
  // code tables, negative-disparity column
  // ---------------------------------------------------------------
  // six-bit sub-blocks abcdei, indexed by EDCBA
  localparam logic [5:0] TAB6 [0:31] = '{
    6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
    6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
    6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
    6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
  // four-bit sub-blocks fghj for data, indexed by HGF
  localparam logic [3:0] TAB4_D [0:7] = '{
    4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};
  // four-bit sub-blocks fghj for special characters
  localparam logic [3:0] TAB4_K [0:7] = '{
    4'hB, 4'h6, 4'hA, 4'hC, 4'hD, 4'h5, 4'h9, 4'h7};
  // the twelve valid special character bytes
  localparam logic [7:0] SPECIAL_BYTES [0:11] = '{
    8'h1C, 8'h3C, 8'h5C, 8'h7C, 8'h9C, 8'hBC, 8'hDC, 8'hFC,
    8'hF7, 8'hFB, 8'hFD, 8'hFE};

  // ---------------------------------------------------------------
  // running disparity and encoding functions
  // ---------------------------------------------------------------
  // R11: sub-block disparity rules
  // disparity at the end of a six-bit sub-block
  function automatic logic rd_after6(input logic rd, input logic [5:0] s);
    int ones;
    ones = $countones(s);
    if (ones > 3 || s == 6'h07)
      return 1'b1;
    else if (ones < 3 || s == 6'h38)
      return 1'b0;
    return rd;
  endfunction

  // disparity at the end of a four-bit sub-block
  function automatic logic rd_after4(input logic rd, input logic [3:0] s);
    int ones;
    ones = $countones(s);
    if (ones > 2 || s == 4'h3)
      return 1'b1;
    else if (ones < 2 || s == 4'hC)
      return 1'b0;
    return rd;
  endfunction

  // R6 R7 R9: byte bits to letters
  // returns {new disparity, abcdeifghj}; byte bit 0 is A, bit 7 is H
  function automatic logic [10:0] encode(input logic [7:0] b, input logic k,
                                         input logic rd);
    logic [4:0] x;
    logic [2:0] y;
    logic kv;
    logic alt;
    logic [5:0] s6;
    logic [3:0] s4;
    logic rdm;
    x = b[4:0];
    y = b[7:5];
    kv = k && (x == 5'h1C || (y == 3'h7 && (x == 5'h17 || x == 5'h1B ||
         x == 5'h1D || x == 5'h1E)));
    s6 = (kv && x == 5'h1C) ? 6'h0F : TAB6[x];
    if (rd && ($countones(s6) != 3 || s6 == 6'h38))
      s6 = ~s6;
    rdm = rd_after6(rd, s6);
    alt = (!rdm && (x == 5'h11 || x == 5'h12 || x == 5'h14)) ||
          (rdm && (x == 5'h0B || x == 5'h0D || x == 5'h0E));
    if (kv)
      s4 = rdm ? ~TAB4_K[y] : TAB4_K[y];
    else
    begin
      s4 = (y == 3'h7 && alt) ? 4'h7 : TAB4_D[y];
      if (rdm && ($countones(s4) != 2 || s4 == 4'hC))
        s4 = ~s4;
    end
    return {rd_after4(rdm, s4), s6, s4};
  endfunction

endpackage

// [rtl/stream_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
// valid/ready word stream between the codec's own modules
interface stream_link_if #(parameter int WIDTH = codec_pkg::FIFO_W);
  logic [WIDTH-1:0] payload; // word carried
  logic valid; // payload present
  logic ready; // sink takes payload
  modport src (output payload, output valid, input ready);
  modport snk (input payload, input valid, output ready);
endinterface
`default_nettype wire

// [rtl/char_fifo.sv]
`timescale 1ns/1ns
`default_nettype none
module char_fifo #(
  parameter int WIDTH = codec_pkg::FIFO_W,
  parameter int DEPTH = codec_pkg::FIFO_DEPTH
) (
  input wire logic clk_i, // character clock
  input wire logic rst_n_i, // asynchronous reset, active low
  stream_link_if.snk wr_port, // filling side
  stream_link_if.src rd_port // draining side
);

  // ---------------------------------------------------------------
  // storage and pointers
  // ---------------------------------------------------------------
  localparam int PW = $clog2(DEPTH); // pointer width
  localparam int CW = $clog2(DEPTH + 1); // occupancy width
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1); // last slot index
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH); // occupancy when full

  logic [WIDTH-1:0] mem_r [0:DEPTH-1]; // word storage
  logic [PW-1:0] wr_ptr_r; // next slot to write
  logic [PW-1:0] rd_ptr_r; // oldest slot
  logic [CW-1:0] count_r; // words held
  wire push_w = wr_port.valid && wr_port.ready; // word accepted
  wire pop_w = rd_port.valid && rd_port.ready; // word drained

  // honest full and empty
  assign wr_port.ready = count_r != CNT_FULL;
  assign rd_port.valid = count_r != '0;
  assign rd_port.payload = mem_r[rd_ptr_r];

  // write the accepted word
  always_ff @(posedge clk_i)
  begin
    if (push_w)
      mem_r[wr_ptr_r] <= wr_port.payload;
  end

  // pointers wrap at the depth, occupancy follows push and pop
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end
    else
    begin
      if (push_w)
        wr_ptr_r <= (wr_ptr_r == PTR_LAST) ? '0 : wr_ptr_r + 1'b1;
      if (pop_w)
        rd_ptr_r <= (rd_ptr_r == PTR_LAST) ? '0 : rd_ptr_r + 1'b1;
      if (push_w && !pop_w)
        count_r <= count_r + 1'b1;
      else if (pop_w && !push_w)
        count_r <= count_r - 1'b1;
    end
  end

endmodule
`default_nettype wire

// [rtl/char_decoder.sv]
`timescale 1ns/1ns
`default_nettype none
module char_decoder (
  input wire logic clk_i, // character clock
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic strobe_i, // a framed character is present
  input wire logic [9:0] code_i, // framed character abcdeifghj
  output logic [7:0] data_o, // decoded byte
  output logic special_char_flag_o, // decoded byte is a special character
  output logic violation_o, // character absent from its column
  output logic valid_o // one-cycle pulse per decoded character
);

  // ---------------------------------------------------------------
  // column search for the current receive disparity
  // ---------------------------------------------------------------
  logic rd_r; // receive running disparity
  logic hit_w; // character found in the column
  logic hit_k_w; // found among the special characters
  logic [7:0] hit_byte_w; // byte that encodes to the character
  logic [10:0] probe_w; // scratch encoder result

  // R13: column search
  always_comb
  begin
    hit_w = 1'b0;
    hit_k_w = 1'b0;
    hit_byte_w = 8'h00;
    probe_w = '0;
    for (int i = 0; i < 256; i++)
    begin
      probe_w = codec_pkg::encode(8'(i), 1'b0, rd_r);
      if (!hit_w && probe_w[9:0] == code_i)
      begin
        hit_w = 1'b1;
        hit_byte_w = 8'(i);
      end
    end
    for (int j = 0; j < codec_pkg::SPECIAL_COUNT; j++)
    begin
      probe_w = codec_pkg::encode(codec_pkg::SPECIAL_BYTES[j], 1'b1, rd_r);
      if (!hit_w && probe_w[9:0] == code_i)
      begin
        hit_w = 1'b1;
        hit_k_w = 1'b1;
        hit_byte_w = codec_pkg::SPECIAL_BYTES[j];
      end
    end
  end

  // new disparity from the received bits, valid or not
  wire rd_nxt = codec_pkg::rd_after4(codec_pkg::rd_after6(rd_r, code_i[9:4]),
                                     code_i[3:0]);

  // ---------------------------------------------------------------
  // registered result
  // ---------------------------------------------------------------
  // R15: byte and flag together
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rd_r <= codec_pkg::RD_RESET;
      data_o <= 8'h00;
      special_char_flag_o <= 1'b0;
      violation_o <= 1'b0;
      valid_o <= 1'b0;
    end
    else
    begin
      valid_o <= strobe_i;
      if (strobe_i)
      begin
        // R13: disparity follows every character
        rd_r <= rd_nxt;
        data_o <= hit_byte_w;
        special_char_flag_o <= hit_k_w;
        violation_o <= !hit_w;
      end
    end
  end

  // R13: violation tied to the search
  property p_violation;
    @(posedge clk_i) disable iff (!rst_n_i)
    strobe_i |=> valid_o && (violation_o == !$past(hit_w));
  endproperty
  a_violation: assert property (p_violation) else $error("violation flag wrong"); // R13

endmodule
`default_nettype wire

// [rtl/eight_b_ten_b_char_codec.sv]
// Overview of operation
// R1: each byte becomes one character, sent serially
// R2: received bits grouped by ten and decoded
// R3: all 256 bytes accepted as data
// R4: idle characters keep transitions on the line
// R5: comma pattern aligns receive character boundaries
// R6: byte bit 0 is A, bit 7 H
// R7: a..h from A..H, i and j derived
// R8: flag low is data, high special
// R9: tables indexed by EDCBA and HGF values
// R10: line order a b c d e i f g h j
// R11: disparity per sub-block, with 000111/111000 cases
// R12: pick column by disparity, then update it
// R13: violation when absent; disparity updates anyway
// R14: tables follow the standard character code
// R15: decoded byte and flag leave together
`timescale 1ns/1ns
`default_nettype none
module eight_b_ten_b_char_codec (
  input wire logic clk_i, // character clock, one line bit per cycle
  input wire logic rst_n_i, // asynchronous reset, active low
  input wire logic [7:0] tx_data_i, // byte to send
  input wire logic tx_special_char_flag_i, // byte is a special character
  input wire logic tx_valid_i, // byte offered
  output logic tx_ready_o, // byte taken into the buffer
  output logic serial_o, // serial line out
  input wire logic serial_i, // serial line in
  output logic [7:0] rx_data_o, // received byte
  output logic rx_special_char_flag_o, // received byte is special
  output logic rx_code_violation_o, // received character invalid
  output logic rx_valid_o, // one-cycle pulse per received byte
  output logic rx_aligned_o // boundaries found by comma
);

  // ---------------------------------------------------------------
  // transmit buffer
  // ---------------------------------------------------------------
  stream_link_if #(.WIDTH(codec_pkg::FIFO_W)) fill_link (); // host to buffer
  stream_link_if #(.WIDTH(codec_pkg::FIFO_W)) drain_link (); // buffer to encoder

  // R8: flag travels beside the byte
  assign fill_link.payload = {tx_special_char_flag_i, tx_data_i};
  assign fill_link.valid = tx_valid_i;
  assign tx_ready_o = fill_link.ready;

  // buffer of 32 words between host and serialiser
  char_fifo #(
    .WIDTH(codec_pkg::FIFO_W),
    .DEPTH(codec_pkg::FIFO_DEPTH)
  ) u_tx_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .wr_port(fill_link),
    .rd_port(drain_link)
  );

  // ---------------------------------------------------------------
  // transmit encoder and serialiser
  // ---------------------------------------------------------------
  logic [3:0] bit_cnt_r; // bit slot within the character on the line
  logic [9:0] cur_code_r; // character being shifted out
  logic tx_rd_r; // transmit running disparity after the character on the line
  wire char_end_w = bit_cnt_r == codec_pkg::LAST_BIT; // last bit on the line

  // R4: idle character when the buffer is empty
  wire [7:0] next_byte_w = drain_link.valid ? drain_link.payload[7:0]
                                            : codec_pkg::IDLE_BYTE;
  wire next_k_w = drain_link.valid ? drain_link.payload[8] : 1'b1;

  // R3: any byte value encodes
  wire [10:0] enc_w = codec_pkg::encode(next_byte_w, next_k_w, tx_rd_r);

  // buffer drains one word per character slot
  assign drain_link.ready = char_end_w;

  // R10: a leaves first, i sits between e and f
  assign serial_o = cur_code_r[codec_pkg::LAST_BIT - bit_cnt_r];

  // R1: shift ten bits, then load the next character
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_cnt_r <= 4'h0;
      cur_code_r <= codec_pkg::IDLE_CODE_NEG;
      // the reset idle character starts negative and leaves disparity positive
      tx_rd_r <= ~codec_pkg::RD_RESET;
    end
    else if (char_end_w)
    begin
      bit_cnt_r <= 4'h0;
      // R12: column chosen, disparity carried forward
      cur_code_r <= enc_w[9:0];
      tx_rd_r <= enc_w[10];
    end
    else
      bit_cnt_r <= bit_cnt_r + 4'h1;
  end

  // ---------------------------------------------------------------
  // receive deserialiser and aligner
  // ---------------------------------------------------------------
  logic [8:0] rx_sr_r; // last nine bits received
  logic [3:0] rx_cnt_r; // bit slot within the received character
  logic rx_aligned_r; // a comma has set the boundary
  wire [9:0] rx_win_w = {rx_sr_r, serial_i}; // ten most recent bits, a at top

  // R5: comma found in abcdeif of the window
  wire comma_w = rx_win_w[9:3] == codec_pkg::COMMA_NEG ||
                 rx_win_w[9:3] == codec_pkg::COMMA_POS;

  // R2: a character is complete every ten bits once aligned
  wire rx_strobe_w = comma_w || (rx_aligned_r && rx_cnt_r == codec_pkg::LAST_BIT);

  // shift in, count bit slots, restart the count on a comma
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rx_sr_r <= '0;
      rx_cnt_r <= 4'h0;
      rx_aligned_r <= 1'b0;
    end
    else
    begin
      rx_sr_r <= rx_win_w[8:0];
      // R5: boundary set by the comma
      if (rx_strobe_w)
        rx_cnt_r <= 4'h0;
      else if (rx_cnt_r != codec_pkg::LAST_BIT)
        rx_cnt_r <= rx_cnt_r + 4'h1;
      if (comma_w)
        rx_aligned_r <= 1'b1;
    end
  end

  assign rx_aligned_o = rx_aligned_r;

  // ---------------------------------------------------------------
  // receive decoder
  // ---------------------------------------------------------------
  // R14: search uses the same code tables as the encoder
  char_decoder u_decoder (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .strobe_i(rx_strobe_w),
    .code_i(rx_win_w),
    .data_o(rx_data_o),
    .special_char_flag_o(rx_special_char_flag_o),
    .violation_o(rx_code_violation_o),
    .valid_o(rx_valid_o)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  property p_bit_wrap;
    @(posedge clk_i) disable iff (!rst_n_i)
    char_end_w |=> bit_cnt_r == 4'h0 ##9 char_end_w;
  endproperty
  a_bit_wrap: assert property (p_bit_wrap) else $error("character not ten bits"); // R1

  property p_first_bit;
    @(posedge clk_i) disable iff (!rst_n_i)
    char_end_w |=> serial_o == $past(enc_w[9]);
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("bit a not sent first"); // R10

  property p_i_bit;
    @(posedge clk_i) disable iff (!rst_n_i)
    char_end_w |=> ##5 serial_o == $past(enc_w[4], 6);
  endproperty
  a_i_bit: assert property (p_i_bit) else $error("bit i not sixth"); // R10

  property p_rd_carry;
    @(posedge clk_i) disable iff (!rst_n_i)
    char_end_w |=> tx_rd_r == codec_pkg::rd_after4(
      codec_pkg::rd_after6($past(tx_rd_r), cur_code_r[9:4]), cur_code_r[3:0]);
  endproperty
  a_rd_carry: assert property (p_rd_carry) else $error("disparity not updated"); // R11

  property p_idle;
    @(posedge clk_i) disable iff (!rst_n_i)
    char_end_w && !drain_link.valid |=>
      cur_code_r == (($past(tx_rd_r)) ? codec_pkg::IDLE_CODE_POS : codec_pkg::IDLE_CODE_NEG);
  endproperty
  a_idle: assert property (p_idle) else $error("idle character wrong"); // R4

  property p_align;
    @(posedge clk_i) disable iff (!rst_n_i)
    comma_w |=> rx_valid_o && rx_cnt_r == 4'h0 && rx_aligned_o;
  endproperty
  a_align: assert property (p_align) else $error("comma did not align"); // R5

  property p_rx_spacing;
    @(posedge clk_i) disable iff (!rst_n_i)
    rx_valid_o && !$past(comma_w) |-> $past(rx_cnt_r) == codec_pkg::LAST_BIT;
  endproperty
  a_rx_spacing: assert property (p_rx_spacing) else $error("receive not ten bits"); // R2

  property p_data_byte;
    @(posedge clk_i) disable iff (!rst_n_i)
    rx_valid_o && !rx_code_violation_o && !rx_special_char_flag_o |->
      codec_pkg::encode(rx_data_o, 1'b0, $past(u_decoder.rd_r)) ==
      {u_decoder.rd_r, $past(rx_win_w)};
  endproperty
  a_data_byte: assert property (p_data_byte) else $error("decoded byte wrong"); // R15

endmodule
`default_nettype wire

// [dv/line_partner.sv]
`timescale 1ns/1ns
`default_nettype none
// ---------------------------------------------------------------
// remote transceiver: loops the line back
// ---------------------------------------------------------------
module line_partner #(
  parameter int DELAY = 2 // bit times around the loop, 2 or more
) (
  input wire logic clk_i, // bit clock
  input wire logic line_i, // line from the codec
  input wire logic flip_i, // corrupt the bit now leaving
  output logic line_o // line back to the codec
);
  logic [DELAY-1:0] pipe_r = '0; // bits in flight, never unknown
  // shift off the codec's sampling edge
  always @(negedge clk_i)
  begin
    pipe_r <= {pipe_r[DELAY-2:0], line_i};
  end
  assign line_o = pipe_r[DELAY-1] ^ flip_i;
endmodule
`default_nettype wire

// [dv/eight_b_ten_b_char_codec_bench.sv]
`timescale 1ns/1ns
`default_nettype none
module eight_b_ten_b_char_codec_bench;
  localparam int CEIL = 20000; // cycle ceiling
  localparam int LOOP = 2; // partner loop delay
  logic clk = 1'b0; // character clock
  logic rst_n; // reset, active low
  logic [7:0] tx_data; // byte offered
  logic tx_flag; // byte is special
  logic tx_valid; // offer strobe
  logic tx_ready; // buffer has room
  logic serial_o; // line out
  logic serial_i; // line back in
  logic [7:0] rx_data; // received byte
  logic rx_flag; // received special
  logic rx_viol; // received violation
  logic rx_valid; // receive pulse
  logic rx_aligned; // framed
  logic flip; // corrupt one bit
  logic locked; // line monitor framed
  logic mrd; // model disparity
  logic [9:0] win; // last ten line bits
  logic [10:0] e; // model character
  logic [8:0] txq[$]; // sent, not yet seen on line
  logic [8:0] rxq[$]; // sent, not yet received
  logic [31:0] r; // random word
  int failures = 0, checked = 0, cycles = 0, seed = 85, pos = 0, viols = 0;
  logic full_seen = 1'b0; // buffer refused once

  eight_b_ten_b_char_codec eight_b_ten_b_char_codec_inst (.clk_i(clk), .rst_n_i(rst_n),
    .tx_data_i(tx_data), .tx_special_char_flag_i(tx_flag), .tx_valid_i(tx_valid),
    .tx_ready_o(tx_ready), .serial_o(serial_o), .serial_i(serial_i), .rx_data_o(rx_data),
    .rx_special_char_flag_o(rx_flag), .rx_code_violation_o(rx_viol), .rx_valid_o(rx_valid),
    .rx_aligned_o(rx_aligned));
  line_partner #(.DELAY(LOOP)) line_partner_inst (.clk_i(clk), .line_i(serial_o),
    .flip_i(flip), .line_o(serial_i));

  // ---------------------------------------------------------------
  // reference model
  // ---------------------------------------------------------------
  // flag high selects one of the twelve specials
  function automatic logic kvalid(input logic [8:0] w);
    kvalid = 1'b0;
    for (int n = 0; n < 12; n++)
      if (w[8] && w[7:0] == codec_pkg::SPECIAL_BYTES[n])
        kvalid = 1'b1;
  endfunction
  function automatic logic rd_next(input logic rd, input int ones, input int half,
                                   input logic up, input logic dn);
    if (ones > half || up)
      return 1'b1;
    if (ones < half || dn)
      return 1'b0;
    return rd;
  endfunction
  function automatic logic [10:0] model_enc(input logic [8:0] w, input logic rd);
    logic [5:0] s6;
    logic [3:0] s4;
    logic r6;
    logic kv;
    logic alt;
    int x;
    kv = kvalid(w);
    x = w[4:0];
    s6 = (kv && x == 28) ? 6'h0F : codec_pkg::TAB6[x];
    if (rd && ($countones(s6) != 3 || s6 == 6'h38))
      s6 = ~s6;
    r6 = rd_next(rd, $countones(s6), 3, s6 == 6'h07, s6 == 6'h38);
    alt = r6 ? (x == 11 || x == 13 || x == 14) : (x == 17 || x == 18 || x == 20);
    s4 = kv ? codec_pkg::TAB4_K[w[7:5]] : (w[7:5] == 3'h7 && alt) ? 4'h7 :
         codec_pkg::TAB4_D[w[7:5]];
    if (r6 && (kv || $countones(s4) != 2 || s4 == 4'hC))
      s4 = ~s4;
    return {rd_next(r6, $countones(s4), 2, s4 == 4'h3, s4 == 4'hC), s6, s4};
  endfunction

  // ---------------------------------------------------------------
  // checking and closing
  // ---------------------------------------------------------------
  task automatic check(input string what, input logic [9:0] seen, input logic [9:0] exp);
    checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // clock and hang guard
  initial
  begin
    forever #20 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == CEIL)
    begin
      failures++;
      print_verdict();
    end
  end

  // line monitor, earliest bit a lands in the msb
  always @(posedge clk)
  begin
    win = {win[8:0], serial_o};
    if (!rst_n)
      locked = 1'b0;
    else if (!locked && win === codec_pkg::IDLE_CODE_NEG)
    begin
      locked = 1'b1;
      pos = 0;
      e = model_enc(9'h1BC, 1'b0);
      mrd = e[10];
    end
    else if (locked)
    begin
      pos = (pos + 1) % 10;
      if (pos == 0)
      begin
        e = model_enc(txq.size() != 0 ? txq[0] : 9'h1BC, mrd);
        if (txq.size() != 0 && win === e[9:0])
          void'(txq.pop_front());
        else
        begin
          e = model_enc(9'h1BC, mrd);
          check("line character", win, e[9:0]);
        end
        mrd = e[10];
      end
    end
  end

  always @(negedge clk)
  begin
    if (!tx_ready)
      full_seen = 1'b1;
    if (rst_n && rx_valid === 1'b1)
    begin
      if (rx_viol === 1'b1)
      begin
        viols++;
        check("violation byte", {rx_flag, rx_data}, 10'h000);
      end
      else if (rxq.size() != 0 && !({rx_flag, rx_data} === 9'h1BC && rxq[0] !== 9'h1BC))
        check("received byte", {rx_viol, rx_flag, rx_data}, rxq.pop_front());
      else
        check("idle byte", {rx_viol, rx_flag, rx_data}, 10'h1BC);
    end
  end

  // offer a byte, held until the edge that takes it
  task automatic send(input logic flag, input logic [7:0] b);
    tx_valid = 1'b1;
    tx_flag = flag;
    tx_data = b;
    while (tx_ready !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    txq.push_back({flag, b});
    rxq.push_back({kvalid({flag, b}), b});
    @(negedge clk);
  endtask
  task automatic drain;
    tx_valid = 1'b0;
    for (int n = 0; n < 4000 && (txq.size() != 0 || rxq.size() != 0); n++)
      @(negedge clk);
    check("line queue empty", txq.size(), 0);
    check("receive queue empty", rxq.size(), 0);
  endtask

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    rst_n = 1'b0;
    tx_valid = 1'b0;
    tx_flag = 1'b0;
    tx_data = 8'h00;
    flip = 1'b0;
    repeat (4) @(negedge clk);
    check("reset outputs", {tx_ready, serial_o, rx_valid, rx_aligned}, 10'h008);
    rst_n = 1'b1;
    for (int n = 0; n < 100 && rx_aligned !== 1'b1; n++)
      @(negedge clk);
    check("aligned by comma", {rx_aligned, locked}, 10'h003);
    $display("test startup done");
    send(1'b0, 8'h45);
    for (int n = 0; n < 12; n++)
      send(1'b1, codec_pkg::SPECIAL_BYTES[n]);
    send(1'b1, 8'h45);
    drain();
    $display("test specials done");
    // every byte value, back to back until refused
    for (int n = 0; n < 256; n++)
      send(1'b0, n[7:0]);
    check("buffer refused", full_seen, 1);
    for (int n = 0; n < 30; n++)
    begin
      r = $random(seed);
      send(r[8] && r[4:0] != 5'h1C, r[7:0]);
    end
    drain();
    $display("test data done");
    // corrupt bit a of one idle character, invalid in either column
    do
    begin
      @(posedge clk);
      #1;
    end
    while (pos != 0);
    repeat (LOOP) @(negedge clk);
    flip = 1'b1;
    @(negedge clk);
    flip = 1'b0;
    repeat (40) @(negedge clk);
    check("violations seen", viols, 1);
    $display("test violation done");
    print_verdict();
  end
endmodule
`default_nettype wire
